// ===== verilog/pcip_pkg.sv
// Package for the port 0 check-bit and interrupt pin block.
// Assumes a single 20 MHz core clock; all pins are synchronous to it.
package pcip_pkg;

  // Location of the port 0 input value within register window 0
  localparam logic [7:0]  PORT0_LOC      = 8'h0E;
  localparam logic [3:0]  PORT0_WINDOW   = 4'h0;

  // Interrupt vectors and numbers
  localparam logic [15:0] NMI_VECTOR     = 16'h203E;
  localparam logic [15:0] EXT_VECTOR     = 16'h200E;
  localparam logic [4:0]  EXT_IRQ_NUM    = 5'h07;
  localparam logic [4:0]  NO_IRQ_NUM     = 5'h00;

  // Port 0 bit that carries the external interrupt when selected
  localparam int          EXT_P0_BIT     = 7;

  // Port 0 bit carrying check bits zero to four
  localparam int          ECB_PIN [5]    = '{6, 0, 2, 1, 3};
  localparam int          ECB_BITS       = 6;

  // Reset values
  localparam logic [7:0]  P0_RST         = 8'h00;
  localparam logic [7:0]  P0_OE_N_RST    = 8'hFF;
  localparam logic [5:0]  ECB_RST        = 6'h00;
  localparam logic [15:0] VECTOR_RST     = 16'h0000;

  // Bus cycle control from the core and correction engine
  typedef struct packed {
    logic       addr_phase;
    logic       data_phase;
    logic       is_read;
    logic       ecb_drive;
    logic [5:0] ecb_out;
  } pcip_bus_t;

  // Interrupt event towards the interrupt controller
  typedef struct packed {
    logic        nmi_req;
    logic        ext_req;
    logic [15:0] vector;
    logic [4:0]  irq_num;
  } pcip_evt_t;

endpackage

// ===== verilog/pcip_edge.sv
// Rising edge detector for interrupt inputs.
// Assumes the input is synchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none

module pcip_edge (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic level_in,
  output logic      rise
);
  import pcip_pkg::*;

  typedef struct packed {
    logic prev;
  } pcip_edge_st_t;

  pcip_edge_st_t st_q;
  pcip_edge_st_t st_d;

  always_comb
  begin
    st_d      = st_q;
    st_d.prev = level_in;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign rise = level_in & ~st_q.prev;

endmodule

`default_nettype wire

// ===== verilog/pcip_pins.sv
// Port 0 check-bit and interrupt pin logic.
// Assumes pins and core controls are synchronous to clk_sys; pin outputs lag one clock.
`timescale 1ns/1ps
`default_nettype none

module pcip_pins (
  input  wire logic                clk_sys,
  input  wire logic                rstn,
  input  wire pcip_pkg::pcip_bus_t bus,
  input  wire logic                check_bits_enable_n,
  input  wire logic [7:0]          p0_in,
  output logic [7:0]               p0_out,
  output logic [7:0]               p0_oe_n,
  input  wire logic                dir_in,
  output logic                     cycle_direction_out,
  output logic                     dir_oe_n,
  output logic [5:0]               ecb_in,
  output logic [7:0]               port0_value,
  input  wire logic                nmi_in,
  input  wire logic                p2_bit2_in,
  input  wire logic                io_control_one_ext_sel,
  input  wire logic                power_down,
  output pcip_pkg::pcip_evt_t      evt,
  output logic                     wake
);
  import pcip_pkg::*;

  typedef struct packed {
    logic [7:0] p0_val;
    logic [7:0] p0_out;
    logic [7:0] p0_oe_n;
    logic       dir_out;
    logic       dir_oe_n;
    logic [5:0] ecb_in;
    pcip_evt_t  evt;
    logic       wake;
  } pcip_st_t;

  pcip_st_t st_q;
  pcip_st_t st_d;
  logic     rst_meta_q;
  logic     rst_n_q;
  logic     external_irq_in;
  logic     ecb_en;
  logic     ecb_tx;
  logic     nmi_rise;
  logic     ext_rise;
  logic [7:0] ecb_oe_n_map;
  logic [7:0] ecb_out_map;
  logic [4:0] ecb_pin_val;

  // Reset release through two flip-flops
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  assign ecb_en          = ~check_bits_enable_n;
  assign ecb_tx          = ecb_en & bus.data_phase & bus.ecb_drive;
  // Source select
  assign external_irq_in = io_control_one_ext_sel ? p0_in[EXT_P0_BIT] : p2_bit2_in;

  // Check bit to port 0 pin mapping
  generate
    for (genvar i = 0; i < 8; i++)
    begin : g_pinmap
      localparam int CB = (i == 6) ? 0 : (i == 0) ? 1 : (i == 2) ? 2 :
                          (i == 1) ? 3 : (i == 3) ? 4 : 5;
      if (CB < 5)
      begin : g_ecb
        assign ecb_oe_n_map[i] = ~ecb_tx;
        assign ecb_out_map[i]  = bus.ecb_out[CB];
        assign ecb_pin_val[CB] = p0_in[i];
      end
      else
      begin : g_in
        assign ecb_oe_n_map[i] = 1'b1;
        assign ecb_out_map[i]  = 1'b0;
      end
    end
  endgenerate

  // Edge detectors for the two interrupt inputs
  generate
    for (genvar j = 0; j < 2; j++)
    begin : g_edge
      logic rise_j;
      pcip_edge u_edge (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n_q),
        .level_in ((j == 0) ? nmi_in : external_irq_in),
        .rise     (rise_j)
      );
      if (j == 0)
      begin : g_nmi
        assign nmi_rise = rise_j;
      end
      else
      begin : g_ext
        assign ext_rise = rise_j;
      end
    end
  endgenerate

  always_comb
  begin
    st_d         = st_q;
    st_d.p0_val  = p0_in;
    st_d.p0_out  = ecb_out_map;
    st_d.p0_oe_n = ecb_oe_n_map;
    if (bus.addr_phase)
    begin
      st_d.dir_oe_n = 1'b0;
      st_d.dir_out  = bus.is_read;
    end
    else if (ecb_tx)
    begin
      st_d.dir_oe_n = 1'b0;
      st_d.dir_out  = bus.ecb_out[5];
    end
    else
    begin
      st_d.dir_oe_n = 1'b1;
      st_d.dir_out  = 1'b0;
    end
    if (ecb_en && bus.data_phase)
      st_d.ecb_in = {dir_in, ecb_pin_val};
    st_d.evt.nmi_req = nmi_rise;
    st_d.evt.ext_req = ext_rise;
    if (nmi_rise)
    begin
      st_d.evt.vector  = NMI_VECTOR;
      st_d.evt.irq_num = NO_IRQ_NUM;
    end
    else if (ext_rise)
    begin
      st_d.evt.vector  = EXT_VECTOR;
      st_d.evt.irq_num = EXT_IRQ_NUM;
    end
    st_d.wake = power_down & external_irq_in;
  end

  always_ff @(posedge clk_sys or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      st_q          <= '0;
      st_q.p0_val   <= P0_RST;
      st_q.p0_oe_n  <= P0_OE_N_RST;
      st_q.dir_oe_n <= 1'b1;
      st_q.ecb_in   <= ECB_RST;
      st_q.evt      <= '0;
    end
    else
      st_q <= st_d;
  end

  assign p0_out              = st_q.p0_out;
  assign p0_oe_n             = st_q.p0_oe_n;
  assign cycle_direction_out = st_q.dir_out;
  assign dir_oe_n            = st_q.dir_oe_n;
  assign ecb_in              = st_q.ecb_in;
  assign port0_value         = st_q.p0_val;
  assign evt                 = st_q.evt;
  assign wake                = st_q.wake;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n_q);

  dir_addr_a: assert property (
    bus.addr_phase |=> !dir_oe_n && cycle_direction_out == $past(bus.is_read))
    else $error("direction pin wrong in address phase");

  dir_ecb_a: assert property (
    !bus.addr_phase && bus.data_phase && bus.ecb_drive && !check_bits_enable_n
    |=> !dir_oe_n && cycle_direction_out == $past(bus.ecb_out[5]))
    else $error("check bit five not driven in data phase");

  ecb_drive_a: assert property (
    bus.data_phase && bus.ecb_drive && !check_bits_enable_n
    |=> p0_oe_n == 8'hB0 && p0_out[6] == $past(bus.ecb_out[0])
        && p0_out[0] == $past(bus.ecb_out[1]) && p0_out[2] == $past(bus.ecb_out[2])
        && p0_out[1] == $past(bus.ecb_out[3]) && p0_out[3] == $past(bus.ecb_out[4]))
    else $error("check bits on wrong port 0 pins");

  ecb_capture_a: assert property (
    bus.data_phase && !check_bits_enable_n
    |=> ecb_in == {$past(dir_in), $past(p0_in[3]), $past(p0_in[1]),
                   $past(p0_in[2]), $past(p0_in[0]), $past(p0_in[6])})
    else $error("check bits captured from wrong pins");

  port_read_a: assert property (
    ##1 port0_value == $past(p0_in))
    else $error("port 0 value not following pins");

  nmi_vector_a: assert property (
    $rose(nmi_in) |=> evt.nmi_req && evt.vector == NMI_VECTOR)
    else $error("nmi edge not vectored");

  ext_p0_a: assert property (
    io_control_one_ext_sel && $stable(io_control_one_ext_sel) && $rose(p0_in[7])
    |=> evt.ext_req)
    else $error("port 0 bit 7 edge missed");

  ext_p2_a: assert property (
    !io_control_one_ext_sel && $stable(io_control_one_ext_sel) && $rose(p2_bit2_in)
    |=> evt.ext_req)
    else $error("port 2 bit 2 edge missed");

  ext_vector_a: assert property (
    evt.ext_req && !evt.nmi_req |-> evt.vector == EXT_VECTOR && evt.irq_num == EXT_IRQ_NUM)
    else $error("external interrupt vector wrong");

  wake_a: assert property (
    power_down && external_irq_in |=> wake)
    else $error("no wake from power down");

  no_drive_a: assert property (
    check_bits_enable_n |=> p0_oe_n == 8'hFF)
    else $error("port 0 driven while check bits disabled");

  read_cycle_c: cover property (bus.addr_phase && bus.is_read ##1 bus.data_phase);
  write_ecb_c:  cover property (bus.data_phase && bus.ecb_drive && !check_bits_enable_n);
  nmi_c:        cover property (evt.nmi_req);
  wake_c:       cover property (power_down ##1 wake);

endmodule

`default_nettype wire

// ===== verif/pcip_far.sv
// Far-side model: external memory check bits and port 0 input sources.
// Assumes device pin controls are registered on clk_sys; enables are active low.
`timescale 1ns/1ps
`default_nettype none

module pcip_far (
  input  wire logic       clk_sys,
  input  wire logic [7:0] p0_out,
  input  wire logic [7:0] p0_oe_n,
  input  wire logic       cycle_direction_out,
  input  wire logic       dir_oe_n,
  input  wire logic       mem_en,
  input  wire logic [5:0] mem_val,
  input  wire logic [7:0] src_val,
  output logic [7:0]      p0_in,
  output logic            dir_in
);
  import pcip_pkg::*;
  logic [7:0] mem_pins;
  logic       dir_last_q = 1'b0;
  // Released direction pin shows a toggling level unless memory drives it; released port 0 pins show src_val or memory bits
  always_comb
  begin
    mem_pins = src_val;
    for (int k = 0; k < 5; k++)
      mem_pins[ECB_PIN[k]] = mem_val[k];
    for (int i = 0; i < 8; i++)
      p0_in[i] = !p0_oe_n[i] ? p0_out[i] : (mem_en ? mem_pins[i] : src_val[i]);
    dir_in = !dir_oe_n ? cycle_direction_out : (mem_en ? mem_val[5] : ~dir_last_q);
  end
  always @(posedge clk_sys)
    dir_last_q <= dir_in;
endmodule

`default_nettype wire

// ===== verif/tb_top.sv
// Testbench for the port 0 check-bit and interrupt pin block.
// Assumes the far-side model pcip_far and a 20 MHz clock.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import pcip_pkg::*;
  logic       clk_sys, rstn, en_n, dir_in, cdo, dir_oe_n, nmi, p2b2, sel, pd, wake, mem_en;
  logic [7:0] p0_in, p0_out, p0_oe_n, p0v, src;
  logic [5:0] ecb_in, mem_val;
  pcip_bus_t  bus;
  pcip_evt_t  evt;
  int         error_cnt, n_compared, cyc;

  pcip_pins dut (.clk_sys(clk_sys), .rstn(rstn), .bus(bus), .check_bits_enable_n(en_n),
    .p0_in(p0_in), .p0_out(p0_out), .p0_oe_n(p0_oe_n), .dir_in(dir_in),
    .cycle_direction_out(cdo), .dir_oe_n(dir_oe_n), .ecb_in(ecb_in), .port0_value(p0v),
    .nmi_in(nmi), .p2_bit2_in(p2b2), .io_control_one_ext_sel(sel), .power_down(pd),
    .evt(evt), .wake(wake));
  pcip_far far (.clk_sys(clk_sys), .p0_out(p0_out), .p0_oe_n(p0_oe_n),
    .cycle_direction_out(cdo), .dir_oe_n(dir_oe_n), .mem_en(mem_en), .mem_val(mem_val),
    .src_val(src), .p0_in(p0_in), .dir_in(dir_in));

  task automatic report_and_stop();
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic step();
    @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  task automatic cmp(input logic [39:0] got, input logic [39:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_req(input bit ext);
    int i;
    for (i = 0; i < 4 && (ext ? evt.ext_req : evt.nmi_req) !== 1'b1; i++)
      step();
    cmp(ext ? evt.ext_req : evt.nmi_req, 1);
    step();
    cmp(ext ? evt.ext_req : evt.nmi_req, 0);
  endtask

  task automatic t_pins();
    logic [7:0] exp;
    logic [5:0] v;
    for (int r = 0; r < 2; r++)
    begin
      bus = '0;
      bus.addr_phase = 1'b1;
      bus.is_read = r[0];
      step();
      cmp({dir_oe_n, cdo}, {1'b0, r[0]});
    end
    en_n = 1'b0;
    for (int n = 0; n < 2; n++)
    begin
      v = n ? 6'h15 : 6'h2A;
      exp = 8'h00;
      for (int k = 0; k < 5; k++)
        exp[ECB_PIN[k]] = v[k];
      bus = '0;
      bus.data_phase = 1'b1;
      bus.ecb_drive = 1'b1;
      bus.ecb_out = v;
      step();
      cmp({p0_oe_n, p0_out}, {8'hB0, exp});
      cmp({dir_oe_n, cdo}, {1'b0, v[5]});
    end
    bus.ecb_drive = 1'b0;
    mem_en = 1'b1;
    mem_val = 6'h33;
    // Device drive of the check bits ends one clock after the write data phase
    step();
    step();
    cmp({ecb_in, p0_oe_n, dir_oe_n}, {6'h33, 8'hFF, 1'b1});
    en_n = 1'b1;
    bus.ecb_drive = 1'b1;
    mem_val = 6'h0C;
    step();
    cmp({ecb_in, p0_oe_n, dir_oe_n}, {6'h33, 8'hFF, 1'b1});
    bus = '0;
    mem_en = 1'b0;
  endtask

  task automatic t_port();
    cmp({PORT0_WINDOW, PORT0_LOC}, {4'h0, 8'h0E});
    for (int n = 0; n < 2; n++)
    begin
      src = n ? 8'h5A : 8'hA5;
      step();
      cmp(p0v, src);
    end
    src = 8'h00;
    step();
  endtask

  task automatic t_irq();
    nmi = 1'b1;
    wait_req(0);
    cmp({evt.vector, evt.irq_num}, {16'h203E, 5'h00});
    nmi = 1'b0;
    for (int s = 0; s < 2; s++)
    begin
      sel = s[0];
      step();
      step();
      if (s)
        p2b2 = 1'b1;
      else
        src[7] = 1'b1;
      for (int i = 0; i < 3; i++)
      begin
        step();
        cmp(evt.ext_req, 0);
      end
      p2b2 = 1'b0;
      src[7] = 1'b0;
      step();
      if (s)
        src[7] = 1'b1;
      else
        p2b2 = 1'b1;
      wait_req(1);
      cmp({evt.vector, evt.irq_num}, {16'h200E, 5'h07});
      p2b2 = 1'b0;
      src[7] = 1'b0;
      step();
    end
    pd = 1'b1;
    step();
    cmp(wake, 0);
    src[7] = 1'b1;
    step();
    cmp(wake, 1);
    pd = 1'b0;
    src[7] = 1'b0;
    step();
    // Both interrupt edges in one cycle: the non-maskable vector wins
    nmi = 1'b1;
    src[7] = 1'b1;
    step();
    cmp({evt.nmi_req, evt.ext_req, evt.vector, evt.irq_num}, {2'b11, 16'h203E, 5'h00});
    nmi = 1'b0;
    src[7] = 1'b0;
    step();
  endtask

  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end

  initial
  begin
    rstn = 1'b0;
    en_n = 1'b1;
    bus = '0;
    nmi = 1'b0;
    p2b2 = 1'b0;
    sel = 1'b0;
    pd = 1'b0;
    mem_en = 1'b0;
    mem_val = 6'h00;
    src = 8'h00;
    repeat (6) @(negedge clk_sys);
    rstn = 1'b1;
    // Internal reset lifts at the second edge after release
    step();
    step();
    t_pins();
    t_port();
    t_irq();
    report_and_stop();
  end
endmodule

`default_nettype wire
